// file: exc_pkg.sv
package exc_pkg;

  // Instruction class as resolved by the decoder
  typedef enum logic [4:0] {
    other_instr,
    jump_register,
    call_register,
    branch_relative,
    call_relative,
    return_subroutine,
    return_exception,
    cond_false_delayed,
    cond_true_delayed,
    call_far_register,
    branch_far_register,
    cond_true_branch,
    cond_false_branch,
    software_trap_instr,
    load_control_sw,
    load_control_postinc_sw,
    load_control,
    load_control_postinc,
    store_control,
    store_control_predec,
    load_system,
    load_system_postinc,
    store_system,
    store_system_predec
  } instr_kind_e;

  typedef enum logic [1:0] {size_byte, size_word, size_long} acc_size_e;

  typedef enum logic [2:0] {
    cause_none, cause_addr_err, cause_slot_illegal, cause_gen_illegal, cause_trap, cause_irq
  } exc_cause_e;

  typedef enum logic [2:0] {st_idle, st_push_sw, st_push_pc, st_vector, st_enter} stack_state_e;

  localparam logic [15:0] UNDEF_LO = 16'hFC00;
  localparam logic [15:0] UNDEF_HI = 16'hFFFF;
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam logic [31:0] TRAP_PC_STEP = 32'h0000_0002;
  localparam int MASK_LSB = 4;
  localparam int MASK_MSB = 7;
  localparam logic [3:0] NMI_MASK_LEVEL = 4'hF;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

endpackage : exc_pkg

// file: instruction_exception_unit.sv
// What this block does
// - Trap pushes status word then PC of the following instruction.
// - Trap handler address read from vector given in opcode, no delay slot.
// - Undefined opcode in a delay slot raises slot-illegal once decoded.
// - PC-changing instruction in a delay slot also raises slot-illegal.
// - Delayed branches listed create a delay slot.
// - Slot-illegal stacks status word, then delayed branch target; own vector.
// - Undefined opcode outside slot: general illegal, stacks its own address.
// - Illegal behaviour guaranteed only for opcodes FC00 to FFFF.
// - Interrupts held in slot or after blocking are taken at next unblocked decode.
// - Address error in slot is taken before the branch executes, slot-illegal after it.
// - Interrupt during slot instruction is taken at the branch destination.
// - Interrupt after a blocking instruction waits one more instruction.
// - Blocking instructions are the control and system load/store forms.
// - Misaligned stacking queues an address error; its own stacking errors ignored.
// - Misaligned stacking still writes, steps by four, low address bits zeroed.
// - Odd fetch, odd word or unaligned longword access is an address error.
// - Non-NMI interrupt accepted only above the status word mask level.
`timescale 1ns/1ps
module instruction_exception_unit #(
  parameter logic [7:0] SLOT_ILLEGAL_VEC = 8'h06,
  parameter logic [7:0] GEN_ILLEGAL_VEC = 8'h04,
  parameter logic [7:0] ADDR_ERR_VEC = 8'h09
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic dec_valid,
  input wire logic [15:0] dec_opcode,
  input wire exc_pkg::instr_kind_e dec_kind,
  input wire logic [31:0] dec_pc,
  input wire logic [31:0] dec_target,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic acc_valid,
  input wire exc_pkg::acc_size_e acc_size,
  input wire logic [31:0] acc_addr,
  input wire logic [31:0] acc_pc,
  input wire logic irq_req,
  input wire logic nmi_req,
  input wire logic [3:0] irq_level,
  input wire logic [7:0] irq_vector,
  input wire logic [31:0] status_word,
  input wire logic [31:0] stack_pointer,
  input wire logic [31:0] vector_base,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic busy,
  output logic flush,
  output logic irq_ack,
  output logic sp_we,
  output logic [31:0] sp_next,
  output logic sw_mask_we,
  output logic [3:0] sw_mask_val,
  output logic redirect_valid,
  output logic [31:0] redirect_pc
);
  import exc_pkg::*;

  function automatic logic is_delayed(input instr_kind_e k);
    is_delayed = k inside {jump_register, call_register, branch_relative, call_relative,
      return_subroutine, return_exception, cond_false_delayed, cond_true_delayed,
      call_far_register, branch_far_register};
  endfunction : is_delayed

  function automatic logic changes_pc(input instr_kind_e k);
    changes_pc = is_delayed(k) || k inside {cond_true_branch, cond_false_branch,
      software_trap_instr, load_control_sw, load_control_postinc_sw};
  endfunction : changes_pc

  function automatic logic is_blocking(input instr_kind_e k);
    is_blocking = k inside {load_control, load_control_postinc, load_control_sw,
      load_control_postinc_sw, store_control, store_control_predec, load_system,
      load_system_postinc, store_system, store_system_predec};
  endfunction : is_blocking

  stack_state_e state_ff;
  exc_cause_e cause_ff;
  logic slot_ff, after_block_ff, ae_pend_ff;
  logic [31:0] target_ff, branch_pc_ff, saved_pc_ff, addr_ff, wdata_ff, handler_ff, sp_next_ff;
  logic [7:0] vec_ff;
  logic [3:0] irq_lvl_ff;

  wire idle = (state_ff == st_idle);
  wire accept = idle && dec_valid;
  wire blocked = slot_ff || after_block_ff;
  wire is_undef = (dec_opcode >= UNDEF_LO) && (dec_opcode <= UNDEF_HI);
  wire acc_bad = acc_valid && ((acc_size == size_word && acc_addr[0]) ||
                               (acc_size == size_long && acc_addr[1:0] != 2'b00));
  wire ae_now = idle && ((fetch_valid && fetch_addr[0]) || acc_bad);
  wire slot_ill = accept && slot_ff && (is_undef || changes_pc(dec_kind));
  wire gen_ill = accept && !slot_ff && is_undef;
  wire trap = accept && !slot_ff && dec_kind == software_trap_instr;
  wire irq_ok = nmi_req ||
                (irq_req && irq_level > status_word[MASK_MSB:MASK_LSB]);
  wire irq_take = accept && !blocked && irq_ok;

  // Fixed priority keeps a single exception per decode
  exc_cause_e cause;
  assign cause = ae_now ? cause_addr_err :
                 slot_ill ? cause_slot_illegal :
                 gen_ill ? cause_gen_illegal :
                 trap ? cause_trap :
                 irq_take ? cause_irq : cause_none;
  wire start = (cause != cause_none);

  // Address errors in the slot point back at the branch so the branch never runs first
  wire [31:0] ae_pc = slot_ff ? branch_pc_ff : acc_pc;
  wire [31:0] nxt_saved_pc = (cause == cause_addr_err) ? ae_pc :
                             (cause == cause_slot_illegal) ? target_ff :
                             (cause == cause_trap) ? dec_pc + TRAP_PC_STEP :
                             dec_pc;
  wire [7:0] nxt_vec = (cause == cause_addr_err) ? ADDR_ERR_VEC :
                       (cause == cause_slot_illegal) ? SLOT_ILLEGAL_VEC :
                       (cause == cause_gen_illegal) ? GEN_ILLEGAL_VEC :
                       (cause == cause_trap) ? dec_opcode[7:0] : irq_vector;
  // A stacking error during address error entry is dropped to avoid a loop
  wire stack_misaligned = (addr_ff[1:0] != 2'b00) && (cause_ff != cause_addr_err);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      slot_ff <= 1'b0;
      after_block_ff <= 1'b0;
      target_ff <= ADDR_RESET;
      branch_pc_ff <= ADDR_RESET;
    end else if (start) begin
      slot_ff <= 1'b0;
      after_block_ff <= 1'b0;
    end else if (accept) begin
      slot_ff <= is_delayed(dec_kind);
      after_block_ff <= is_blocking(dec_kind);
      if (is_delayed(dec_kind)) begin
        target_ff <= dec_target;
        branch_pc_ff <= dec_pc;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_ff <= st_idle;
      cause_ff <= cause_none;
      ae_pend_ff <= 1'b0;
      saved_pc_ff <= ADDR_RESET;
      addr_ff <= ADDR_RESET;
      wdata_ff <= ADDR_RESET;
      handler_ff <= ADDR_RESET;
      sp_next_ff <= ADDR_RESET;
      vec_ff <= 8'h00;
      irq_lvl_ff <= 4'h0;
    end else begin
      case (state_ff)
        st_idle: if (start) begin
          state_ff <= st_push_sw;
          cause_ff <= cause;
          saved_pc_ff <= nxt_saved_pc;
          vec_ff <= nxt_vec;
          irq_lvl_ff <= nmi_req ? NMI_MASK_LEVEL : irq_level;
          addr_ff <= stack_pointer - STACK_STEP;
          wdata_ff <= status_word;
        end
        st_push_sw: if (mem_ack) begin
          state_ff <= st_push_pc;
          addr_ff <= addr_ff - STACK_STEP;
          wdata_ff <= saved_pc_ff;
          if (stack_misaligned) ae_pend_ff <= 1'b1;
        end
        st_push_pc: if (mem_ack) begin
          state_ff <= st_vector;
          sp_next_ff <= addr_ff;
          addr_ff <= vector_base + {22'h000000, vec_ff, 2'b00};
          if (stack_misaligned) ae_pend_ff <= 1'b1;
        end
        st_vector: if (mem_ack) begin
          state_ff <= st_enter;
          handler_ff <= mem_rdata;
        end
        st_enter: if (ae_pend_ff) begin
          // Queued address error starts right after the first entry completes
          state_ff <= st_push_sw;
          ae_pend_ff <= 1'b0;
          cause_ff <= cause_addr_err;
          saved_pc_ff <= handler_ff;
          vec_ff <= ADDR_ERR_VEC;
          addr_ff <= sp_next_ff - STACK_STEP;
          wdata_ff <= status_word;
        end else begin
          state_ff <= st_idle;
        end
        default: state_ff <= st_idle;
      endcase
    end
  end

  assign mem_req = (state_ff == st_push_sw) || (state_ff == st_push_pc) || (state_ff == st_vector);
  assign mem_we = (state_ff == st_push_sw) || (state_ff == st_push_pc);
  assign mem_addr = {addr_ff[31:2], 2'b00};
  assign mem_wdata = wdata_ff;
  assign busy = !idle;
  assign flush = start;
  assign irq_ack = start && cause == cause_irq;
  assign redirect_valid = (state_ff == st_enter);
  assign redirect_pc = handler_ff;
  assign sp_we = (state_ff == st_enter);
  assign sp_next = sp_next_ff;
  assign sw_mask_we = (state_ff == st_enter) && cause_ff == cause_irq;
  assign sw_mask_val = irq_lvl_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_trap_saved_pc: assert property (
    trap && cause == cause_trap |=> saved_pc_ff == $past(dec_pc) + TRAP_PC_STEP)
    else $error("trap saved pc wrong");
  chk_trap_vector: assert property (
    cause == cause_trap |=> vec_ff == $past(dec_opcode[7:0]))
    else $error("trap vector wrong");
  chk_push_order: assert property (
    state_ff == st_push_sw && mem_ack |=> state_ff == st_push_pc && mem_wdata == saved_pc_ff)
    else $error("push order wrong");
  chk_slot_target: assert property (
    cause == cause_slot_illegal |=> saved_pc_ff == $past(target_ff) && vec_ff == SLOT_ILLEGAL_VEC)
    else $error("slot illegal pc wrong");
  chk_gen_illegal: assert property (
    accept && !slot_ff && dec_opcode >= UNDEF_LO && !ae_now |-> cause == cause_gen_illegal)
    else $error("general illegal missed");
  chk_slot_detect: assert property (
    accept && slot_ff && changes_pc(dec_kind) && !ae_now |-> cause == cause_slot_illegal)
    else $error("slot illegal missed");
  // Judged from the decoded class, not from the hold flags the logic itself uses
  chk_irq_hold: assert property (
    accept && !start && (is_delayed(dec_kind) || is_blocking(dec_kind)) |=> !irq_ack)
    else $error("interrupt taken while held");
  chk_irq_level: assert property (
    irq_ack && !nmi_req |-> irq_level > status_word[MASK_MSB:MASK_LSB])
    else $error("interrupt below mask");
  chk_stack_align: assert property (
    mem_req && mem_we |-> mem_addr[1:0] == 2'b00)
    else $error("stack address unaligned");
  chk_ae_no_loop: assert property (
    state_ff == st_enter && cause_ff == cause_addr_err |-> !ae_pend_ff)
    else $error("address error looped");
  chk_one_entry: assert property (
    start |=> !start ##1 !start)
    else $error("two entries overlap");

  cov_trap: cover property (cause == cause_trap ##[1:40] redirect_valid);
  cov_slot_illegal: cover property (cause == cause_slot_illegal);
  cov_irq_after_slot: cover property (slot_ff && irq_ok ##1 irq_ack);
  cov_chained_ae: cover property (state_ff == st_enter && ae_pend_ff);

endmodule : instruction_exception_unit

// file: mem_partner.sv
`timescale 1ns/1ps
module mem_partner (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] wait_cycles,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  localparam logic [31:0] HANDLER_MARK = 32'hA000_0000;
  logic [1:0] wait_ff;
  logic [31:0] junk_ff;
  // Idle read data toggles every cycle so a stale vector can never pass for a fresh one
  assign mem_rdata = (mem_ack && !mem_we) ? (mem_addr ^ HANDLER_MARK) : junk_ff;
  always_ff @(posedge sys_clk) begin
    junk_ff <= nrst ? ~junk_ff : 32'h5A5A_5A5A;
    if (!nrst || !mem_req || mem_ack) begin
      mem_ack <= 1'b0;
      wait_ff <= 2'h0;
    end else if (wait_ff == wait_cycles) begin
      mem_ack <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule : mem_partner

// file: instruction_exception_unit_tb.sv
`timescale 1ns/1ps
module instruction_exception_unit_tb;
  import exc_pkg::*;
  localparam logic [31:0] HANDLER_MARK = 32'hA000_0000;
  localparam logic [7:0] SLOT_VEC = 8'h06;
  localparam logic [7:0] GEN_VEC = 8'h04;
  localparam logic [7:0] ADDR_VEC = 8'h09;
  logic sys_clk = 1'b0, nrst = 1'b0, dec_valid = 1'b0, fetch_valid = 1'b0, acc_valid = 1'b0;
  logic irq_req = 1'b0, nmi_req = 1'b0, mem_req, mem_we, mem_ack, busy, flush, irq_ack;
  logic sp_we, sw_mask_we, redirect_valid;
  logic [15:0] dec_opcode = 16'h0000;
  logic [3:0] irq_level = 4'h6, sw_mask_val;
  logic [7:0] irq_vector = 8'h40;
  logic [1:0] slow = 2'h0;
  logic [31:0] dec_pc = 32'h0, dec_target = 32'h0, fetch_addr = 32'h0, acc_addr = 32'h0;
  logic [31:0] acc_pc = 32'h0, status_word = 32'h30, vector_base = 32'h400;
  logic [31:0] stack_pointer = 32'h2000, mem_addr, mem_wdata, mem_rdata, sp_next, redirect_pc;
  logic [31:0] wa[$], wd[$], ra[$], rp[$], sn[$], mw[$], mv[$], fq[$];
  instr_kind_e dec_kind = other_instr;
  acc_size_e acc_size = size_byte;
  int fails = 0, cmp_count = 0, cyc = 0;

  instruction_exception_unit #(.SLOT_ILLEGAL_VEC(SLOT_VEC), .GEN_ILLEGAL_VEC(GEN_VEC),
    .ADDR_ERR_VEC(ADDR_VEC)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
    .dec_kind(dec_kind), .dec_pc(dec_pc), .dec_target(dec_target),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .acc_valid(acc_valid),
    .acc_size(acc_size), .acc_addr(acc_addr), .acc_pc(acc_pc), .irq_req(irq_req),
    .nmi_req(nmi_req), .irq_level(irq_level), .irq_vector(irq_vector),
    .status_word(status_word), .stack_pointer(stack_pointer), .vector_base(vector_base),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy), .flush(flush),
    .irq_ack(irq_ack), .sp_we(sp_we), .sp_next(sp_next), .sw_mask_we(sw_mask_we),
    .sw_mask_val(sw_mask_val), .redirect_valid(redirect_valid), .redirect_pc(redirect_pc));
  mem_partner partner (.sys_clk(sys_clk), .nrst(nrst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .wait_cycles(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (mem_req && mem_ack && mem_we) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
    end
    if (mem_req && mem_ack && !mem_we) ra.push_back(mem_addr);
    if (redirect_valid) begin
      rp.push_back(redirect_pc);
      sn.push_back(sp_next);
      mw.push_back(32'({sp_we, sw_mask_we}));
      mv.push_back(32'(sw_mask_val));
    end
    // Survives idle(), which clears the other queues but not fq; entry() clears it
    if (flush === 1'b1) fq.push_back(32'(irq_ack));
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic dec(input instr_kind_e k, input logic [15:0] op, input logic [31:0] pc, tg);
    dec_valid = 1'b1;
    dec_kind = k;
    dec_opcode = op;
    dec_pc = pc;
    dec_target = tg;
    @(negedge sys_clk);
  endtask : dec

  task automatic idle();
    dec_valid = 1'b0;
    irq_req = 1'b0;
    fetch_valid = 1'b0;
    acc_valid = 1'b0;
    wa.delete();
    wd.delete();
    ra.delete();
    rp.delete();
    sn.delete();
    mw.delete();
    mv.delete();
    @(negedge sys_clk);
  endtask : idle

  task automatic entry(input logic [31:0] sp, spc, input logic [7:0] vec, input int n, bit full);
    int i;
    bit irq;
    logic [31:0] va;
    irq = (vec == irq_vector);
    va = vector_base + (32'(vec) << 2);
    chk("busy", 32'h1, 32'(busy));
    for (i = 0; i < 200 && (busy === 1'b1 || rp.size() < n); i++) @(negedge sys_clk);
    chk("entry count", 32'(n), 32'(rp.size()));
    chk("flush count", 32'h1, 32'(fq.size()));
    chk("irq ack", 32'(irq), fq[0]);
    chk("status addr", (sp - 32'h4) & 32'hFFFF_FFFC, wa[0]);
    chk("pc addr", (sp - 32'h8) & 32'hFFFF_FFFC, wa[1]);
    if (full) chk("status data", status_word, wd[0]);
    if (full) chk("saved pc", spc, wd[1]);
    chk("vector addr", va, ra[0]);
    chk("handler", va ^ HANDLER_MARK, rp[0]);
    chk("new sp", sp - 32'h8, sn[0]);
    chk("entry strobes", irq ? 32'h3 : 32'h2, mw[0]);
    if (irq) chk("mask level", nmi_req ? 32'hF : 32'(irq_level), mv[0]);
    fq.delete();
  endtask : entry

  task automatic t_instr();
    int i;
    dec(software_trap_instr, 16'hC321, 32'h100, 32'h0);
    idle();
    entry(stack_pointer, 32'h102, 8'h21, 1, 1'b1);
    dec(other_instr, 16'hFFFF, 32'h240, 32'h0);
    idle();
    entry(stack_pointer, 32'h240, GEN_VEC, 1, 1'b1);
    for (i = 0; i <= 15; i++) begin
      // A faulting slot behind return_exception is kept out on purpose
      dec(instr_kind_e'((i % 10) + 1 + ((i % 10) == 5)), 16'h0009, 32'h300,
        32'(i * 16));
      dec(instr_kind_e'(i), (i == 0) ? 16'hFC00 : 16'h0009, 32'h302,
        32'h0);
      idle();
      entry(stack_pointer, 32'(i * 16), SLOT_VEC, 1, 1'b1);
    end
    $display("instruction exception test done");
  endtask : t_instr

  task automatic t_irq();
    int k;
    for (k = 16; k <= 24; k++) begin
      dec((k == 24) ? return_exception : instr_kind_e'(k), 16'h4007, 32'h200,
        32'h900);
      irq_req = 1'b1;
      dec(other_instr, 16'h0009, 32'h202, 32'h0);
      dec(other_instr, 16'h0009, 32'h204, 32'h0);
      idle();
      entry(stack_pointer, 32'h204, irq_vector, 1, 1'b1);
    end
    status_word = 32'h60;
    irq_req = 1'b1;
    dec(other_instr, 16'hFBFF, 32'h220, 32'h0);
    idle();
    repeat (10) @(negedge sys_clk);
    chk("refused entries", 32'h0, 32'(rp.size()));
    chk("refused flush", 32'h0, 32'(fq.size()));
    status_word = 32'h50;
    irq_req = 1'b1;
    dec(other_instr, 16'h0009, 32'h224, 32'h0);
    idle();
    entry(stack_pointer, 32'h224, irq_vector, 1, 1'b1);
    // Non-maskable request passes even the highest mask and loads level F
    status_word = 32'hF0;
    nmi_req = 1'b1;
    dec(other_instr, 16'h0009, 32'h228, 32'h0);
    idle();
    entry(stack_pointer, 32'h228, irq_vector, 1, 1'b1);
    nmi_req = 1'b0;
    status_word = 32'h30;
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_addr_err();
    int i;
    for (i = 0; i <= 3; i++) begin
      // Last pass faults outside a slot, so the faulting instruction itself is stacked
      if (i != 3) dec(branch_relative, 16'hA001, 32'h800, 32'hA00);
      fetch_valid = (i == 0);
      acc_valid = (i != 0);
      acc_size = (i == 1) ? size_word : size_long;
      acc_addr = (i == 1) ? 32'h1001 : 32'h1002;
      fetch_addr = 32'hA03;
      acc_pc = 32'h802;
      dec(other_instr, 16'h0009, 32'h802, 32'h0);
      idle();
      entry(stack_pointer, (i == 3) ? 32'h802 : 32'h800, ADDR_VEC, 1, 1'b1);
    end
    stack_pointer = 32'h2002;
    slow = 2'h2;
    dec(software_trap_instr, 16'hC321, 32'h100, 32'h0);
    idle();
    entry(32'h2002, 32'h102, 8'h21, 2, 1'b0);
    chk("second status addr", 32'h1FF4, wa[2]);
    chk("second pc addr", 32'h1FF0, wa[3]);
    chk("second vector", vector_base + (32'(ADDR_VEC) << 2), ra[1]);
    chk("second sp", 32'h1FF2, sn[1]);
    chk("second strobes", 32'h2, mw[1]);
    $display("address error test done");
  endtask : t_addr_err

  initial begin
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    t_instr();
    t_irq();
    t_addr_err();
    results();
  end
endmodule : instruction_exception_unit_tb
